// file: common/cpurf_pkg.sv
// package: shared constants and carrier types for the cpu register file and flags
package cpurf_pkg;
  localparam int unsigned NUM_REGS = 8;
  localparam int unsigned REG_W = 32;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned PC_W = 24;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned ADDR20_W = 20;
  localparam logic [IDX_W-1:0] STACK_IDX = 3'h7;
  localparam logic [2:0] BIT_I = 3'h7;
  localparam logic [2:0] BIT_UI = 3'h6;
  localparam logic [2:0] BIT_H = 3'h5;
  localparam logic [2:0] BIT_U = 3'h4;
  localparam logic [2:0] BIT_N = 3'h3;
  localparam logic [2:0] BIT_Z = 3'h2;
  localparam logic [2:0] BIT_V = 3'h1;
  localparam logic [2:0] BIT_C = 3'h0;
  localparam logic [PC_W-1:0] PC_ALIGN_MASK = 24'hFFFFFE;
  localparam logic [PC_W-1:0] NORMAL_MASK = 24'h00FFFF;
  localparam logic [PC_W-1:0] MB1_MASK = 24'h0FFFFF;
  localparam logic [PC_W-1:0] ADV_MASK = 24'hFFFFFF;
  localparam logic [FLAG_W-1:0] FLAG_RESET_I = 8'h80;

  // view of a general register selected by an access
  typedef enum logic [2:0] {
    CPURF_SZ_LONG,
    CPURF_SZ_EXT,
    CPURF_SZ_LOWER,
    CPURF_SZ_HIGH_BYTE,
    CPURF_SZ_LOW_BYTE
  } cpurf_size_t;

  // operand size of an arithmetic flag update
  typedef enum logic [1:0] {
    CPURF_OP_BYTE,
    CPURF_OP_WORD,
    CPURF_OP_LONG
  } cpurf_opsz_t;

  // how the flag register is changed this cycle
  typedef enum logic [3:0] {
    CPURF_FL_NONE,
    CPURF_FL_ARITH,
    CPURF_FL_LOGIC,
    CPURF_FL_SHIFT,
    CPURF_FL_BITACC,
    CPURF_FL_LOAD,
    CPURF_FL_AND,
    CPURF_FL_OR,
    CPURF_FL_XOR
  } cpurf_flop_t;

  // address space modes
  typedef enum logic [1:0] {
    CPURF_AS_NORMAL,
    CPURF_AS_MB1,
    CPURF_AS_ADVANCED
  } cpurf_aspace_t;

  // branch condition codes, four-bit form
  typedef enum logic [3:0] {
    CPURF_CC_T, CPURF_CC_F, CPURF_CC_HI, CPURF_CC_LS,
    CPURF_CC_CC, CPURF_CC_CS, CPURF_CC_NE, CPURF_CC_EQ,
    CPURF_CC_VC, CPURF_CC_VS, CPURF_CC_PL, CPURF_CC_MI,
    CPURF_CC_GE, CPURF_CC_LT, CPURF_CC_GT, CPURF_CC_LE
  } cpurf_cond_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    cpurf_size_t size;
    logic [REG_W-1:0] data;
  } cpurf_wr_t;

  typedef struct packed {
    cpurf_opsz_t opsz;
    logic sub;
    logic [REG_W-1:0] a;
    logic [REG_W-1:0] b;
    logic cin;
  } cpurf_arith_t;

  typedef struct packed {
    cpurf_flop_t op;
    cpurf_opsz_t opsz;
    logic [REG_W-1:0] result;
    logic shift_out;
    logic bit_val;
    logic [FLAG_W-1:0] imm;
  } cpurf_flag_cmd_t;
endpackage

// file: src/cpurf_arith.sv
// adder/subtractor producing result and half-carry, carry and overflow per size
`timescale 1ns/1ps
`default_nettype none
module cpurf_arith (
  input wire cpurf_pkg::cpurf_arith_t i_op,
  output logic [cpurf_pkg::REG_W-1:0] o_result,
  output logic o_half,
  output logic o_carry,
  output logic o_ovf
);
  // subtraction as a + ~b + 1 - borrow: carry-out inverted gives the borrow
  wire [cpurf_pkg::REG_W-1:0] b_eff = i_op.sub ? ~i_op.b : i_op.b;
  wire cin_eff = i_op.sub ? ~i_op.cin : i_op.cin;
  wire [cpurf_pkg::REG_W:0] sum = {1'b0, i_op.a} + {1'b0, b_eff} + {32'h0, cin_eff};
  wire [12:0] lo12 = {1'b0, i_op.a[11:0]} + {1'b0, b_eff[11:0]} + {12'h0, cin_eff};
  wire [4:0] lo4 = {1'b0, i_op.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
  wire [28:0] lo28 = {1'b0, i_op.a[27:0]} + {1'b0, b_eff[27:0]} + {28'h0, cin_eff};
  wire [8:0] lo8 = {1'b0, i_op.a[7:0]} + {1'b0, b_eff[7:0]} + {8'h0, cin_eff};
  wire [16:0] lo16 = {1'b0, i_op.a[15:0]} + {1'b0, b_eff[15:0]} + {16'h0, cin_eff};
  logic hc;
  logic cy;
  logic sa;
  logic sb;
  logic sr;

  always_comb begin
    o_result = sum[cpurf_pkg::REG_W-1:0];
    unique case (i_op.opsz)
      cpurf_pkg::CPURF_OP_BYTE: begin
        hc = lo4[4];
        cy = lo8[8];
        sa = i_op.a[7];
        sb = b_eff[7];
        sr = sum[7];
      end
      cpurf_pkg::CPURF_OP_WORD: begin
        hc = lo12[12];
        cy = lo16[16];
        sa = i_op.a[15];
        sb = b_eff[15];
        sr = sum[15];
      end
      default: begin
        hc = lo28[28];
        cy = sum[cpurf_pkg::REG_W];
        sa = i_op.a[31];
        sb = b_eff[31];
        sr = sum[31];
      end
    endcase
    o_half = hc ^ i_op.sub;
    o_carry = cy ^ i_op.sub;
    o_ovf = (sa == sb) && (sr != sa);
  end
endmodule
`default_nettype wire

// file: src/cpurf_cond.sv
// branch condition evaluation from the negative, zero, overflow and carry flags
`timescale 1ns/1ps
`default_nettype none
module cpurf_cond (
  input wire logic [cpurf_pkg::FLAG_W-1:0] i_flags,
  input wire cpurf_pkg::cpurf_cond_t i_cond,
  output logic o_taken
);
  wire n = i_flags[cpurf_pkg::BIT_N];
  wire z = i_flags[cpurf_pkg::BIT_Z];
  wire v = i_flags[cpurf_pkg::BIT_V];
  wire c = i_flags[cpurf_pkg::BIT_C];

  always_comb begin
    unique case (i_cond)
      cpurf_pkg::CPURF_CC_T: o_taken = 1'b1;
      cpurf_pkg::CPURF_CC_F: o_taken = 1'b0;
      cpurf_pkg::CPURF_CC_HI: o_taken = ~(c | z);
      cpurf_pkg::CPURF_CC_LS: o_taken = c | z;
      cpurf_pkg::CPURF_CC_CC: o_taken = ~c;
      cpurf_pkg::CPURF_CC_CS: o_taken = c;
      cpurf_pkg::CPURF_CC_NE: o_taken = ~z;
      cpurf_pkg::CPURF_CC_EQ: o_taken = z;
      cpurf_pkg::CPURF_CC_VC: o_taken = ~v;
      cpurf_pkg::CPURF_CC_VS: o_taken = v;
      cpurf_pkg::CPURF_CC_PL: o_taken = ~n;
      cpurf_pkg::CPURF_CC_MI: o_taken = n;
      cpurf_pkg::CPURF_CC_GE: o_taken = ~(n ^ v);
      cpurf_pkg::CPURF_CC_LT: o_taken = n ^ v;
      cpurf_pkg::CPURF_CC_GT: o_taken = ~(z | (n ^ v));
      cpurf_pkg::CPURF_CC_LE: o_taken = z | (n ^ v);
    endcase
  end
endmodule
`default_nettype wire

// file: src/cpurf_top.sv
// cpu architectural state: general registers, instruction pointer, condition flags
`timescale 1ns/1ps
`default_nettype none
module cpurf_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [cpurf_pkg::PC_W-1:0] i_reset_vector,
  input wire cpurf_pkg::cpurf_wr_t i_wr,
  input wire logic [cpurf_pkg::IDX_W-1:0] i_rd_a_idx,
  input wire cpurf_pkg::cpurf_size_t i_rd_a_size,
  input wire logic [cpurf_pkg::IDX_W-1:0] i_rd_b_idx,
  input wire cpurf_pkg::cpurf_size_t i_rd_b_size,
  input wire logic i_sp_wr,
  input wire logic [cpurf_pkg::REG_W-1:0] i_sp_data,
  input wire logic i_pc_load,
  input wire logic [cpurf_pkg::PC_W-1:0] i_pc_data,
  input wire logic i_pc_step,
  input wire cpurf_pkg::cpurf_flag_cmd_t i_flag_cmd,
  input wire cpurf_pkg::cpurf_arith_t i_arith,
  input wire logic i_exc_start,
  input wire logic i_irq_req,
  input wire logic i_irq_ui_masked,
  input wire logic i_ui_as_mask,
  input wire logic i_nmi_req,
  input wire cpurf_pkg::cpurf_cond_t i_cond,
  input wire cpurf_pkg::cpurf_aspace_t i_aspace,
  input wire logic [cpurf_pkg::PC_W-1:0] i_eff_addr,
  input wire logic i_wide_access,
  output logic [cpurf_pkg::REG_W-1:0] o_rd_a,
  output logic [cpurf_pkg::REG_W-1:0] o_rd_b,
  output logic [cpurf_pkg::REG_W-1:0] o_stack_ptr,
  output logic [cpurf_pkg::PC_W-1:0] o_instruction_pointer,
  output logic [cpurf_pkg::PC_W-1:0] o_fetch_addr,
  output logic [cpurf_pkg::FLAG_W-1:0] o_condition_flags,
  output logic [cpurf_pkg::REG_W-1:0] o_arith_result,
  output logic o_branch_taken,
  output logic o_irq_accept,
  output logic o_nmi_accept,
  output logic [cpurf_pkg::PC_W-1:0] o_bus_addr
);
  // general registers have no reset: undefined after reset
  logic [cpurf_pkg::REG_W-1:0] gen_reg [cpurf_pkg::NUM_REGS];
  logic [cpurf_pkg::PC_W-1:0] ip_reg;
  logic [cpurf_pkg::PC_W-1:0] ip_next;
  logic [cpurf_pkg::FLAG_W-1:0] flags_reg;
  logic [cpurf_pkg::FLAG_W-1:0] flags_next;
  logic [cpurf_pkg::REG_W-1:0] rd_a_reg;
  logic [cpurf_pkg::REG_W-1:0] rd_b_reg;
  logic [cpurf_pkg::REG_W-1:0] sp_reg;
  logic [cpurf_pkg::PC_W-1:0] fetch_reg;
  logic [cpurf_pkg::REG_W-1:0] arith_reg;
  logic taken_reg;
  logic irq_acc_reg;
  logic nmi_acc_reg;
  logic [cpurf_pkg::PC_W-1:0] bus_addr_reg;

  // read view of a register: narrow views are zero-extended into the low bits
  function automatic logic [cpurf_pkg::REG_W-1:0] view_rd(
    input logic [cpurf_pkg::REG_W-1:0] r,
    input cpurf_pkg::cpurf_size_t sz
  );
    logic [cpurf_pkg::REG_W-1:0] v;
    v = r;
    unique case (sz)
      cpurf_pkg::CPURF_SZ_LONG: v = r;
      cpurf_pkg::CPURF_SZ_EXT: v = {16'h0000, r[31:16]};
      cpurf_pkg::CPURF_SZ_LOWER: v = {16'h0000, r[15:0]};
      cpurf_pkg::CPURF_SZ_HIGH_BYTE: v = {24'h000000, r[15:8]};
      cpurf_pkg::CPURF_SZ_LOW_BYTE: v = {24'h000000, r[7:0]};
      default: v = r;
    endcase
    return v;
  endfunction

  // merge of write data into the old value for the selected view
  function automatic logic [cpurf_pkg::REG_W-1:0] view_wr(
    input logic [cpurf_pkg::REG_W-1:0] r,
    input cpurf_pkg::cpurf_size_t sz,
    input logic [cpurf_pkg::REG_W-1:0] d
  );
    logic [cpurf_pkg::REG_W-1:0] v;
    v = r;
    unique case (sz)
      cpurf_pkg::CPURF_SZ_LONG: v = d;
      cpurf_pkg::CPURF_SZ_EXT: v = {d[15:0], r[15:0]};
      cpurf_pkg::CPURF_SZ_LOWER: v = {r[31:16], d[15:0]};
      cpurf_pkg::CPURF_SZ_HIGH_BYTE: v = {r[31:16], d[7:0], r[7:0]};
      cpurf_pkg::CPURF_SZ_LOW_BYTE: v = {r[31:8], d[7:0]};
      default: v = r;
    endcase
    return v;
  endfunction

  // space mask applied to any address, word alignment only when align is set
  function automatic logic [cpurf_pkg::PC_W-1:0] form_addr(
    input logic [cpurf_pkg::PC_W-1:0] a,
    input cpurf_pkg::cpurf_aspace_t m,
    input logic align
  );
    logic [cpurf_pkg::PC_W-1:0] v;
    unique case (m)
      cpurf_pkg::CPURF_AS_NORMAL: v = a & cpurf_pkg::NORMAL_MASK;
      cpurf_pkg::CPURF_AS_MB1: v = a & cpurf_pkg::MB1_MASK;
      cpurf_pkg::CPURF_AS_ADVANCED: v = a & cpurf_pkg::ADV_MASK;
      default: v = a & cpurf_pkg::ADV_MASK;
    endcase
    return align ? (v & cpurf_pkg::PC_ALIGN_MASK) : v;
  endfunction

  // the stack port wins over a datapath write to register 7
  genvar gi;
  generate
    for (gi = 0; gi < cpurf_pkg::NUM_REGS; gi++) begin : g_regs
      wire hit = i_wr.en && (i_wr.idx == cpurf_pkg::IDX_W'(gi));
      wire sp_hit = i_sp_wr && (cpurf_pkg::IDX_W'(gi) == cpurf_pkg::STACK_IDX);
      wire [cpurf_pkg::REG_W-1:0] merged = view_wr(gen_reg[gi], i_wr.size, i_wr.data);
      always_ff @(posedge i_clk) begin
        if (sp_hit) begin
          gen_reg[gi] <= i_sp_data;
        end else if (hit) begin
          gen_reg[gi] <= merged;
        end
      end
    end
  endgenerate

  // arithmetic unit feeds half-carry, carry and overflow
  logic [cpurf_pkg::REG_W-1:0] ar_res;
  logic ar_h;
  logic ar_c;
  logic ar_v;
  cpurf_arith u_arith (
    .i_op(i_arith),
    .o_result(ar_res),
    .o_half(ar_h),
    .o_carry(ar_c),
    .o_ovf(ar_v)
  );

  logic cond_taken;
  cpurf_cond u_cond (
    .i_flags(flags_reg),
    .i_cond(i_cond),
    .o_taken(cond_taken)
  );

  // sign and zero of the result at the operand size
  wire [cpurf_pkg::REG_W-1:0] res_src =
    (i_flag_cmd.op == cpurf_pkg::CPURF_FL_ARITH) ? ar_res : i_flag_cmd.result;
  wire res_sign = (i_flag_cmd.opsz == cpurf_pkg::CPURF_OP_BYTE) ? res_src[7] :
                  (i_flag_cmd.opsz == cpurf_pkg::CPURF_OP_WORD) ? res_src[15] : res_src[31];
  wire res_zero = (i_flag_cmd.opsz == cpurf_pkg::CPURF_OP_BYTE) ? (res_src[7:0] == 8'h00) :
                  (i_flag_cmd.opsz == cpurf_pkg::CPURF_OP_WORD) ? (res_src[15:0] == 16'h0000) :
                  (res_src == 32'h00000000);

  always_comb begin
    flags_next = flags_reg;
    unique case (i_flag_cmd.op)
      cpurf_pkg::CPURF_FL_NONE: flags_next = flags_reg;
      cpurf_pkg::CPURF_FL_ARITH: begin
        flags_next[cpurf_pkg::BIT_H] = ar_h;
        flags_next[cpurf_pkg::BIT_N] = res_sign;
        flags_next[cpurf_pkg::BIT_Z] = res_zero;
        flags_next[cpurf_pkg::BIT_V] = ar_v;
        flags_next[cpurf_pkg::BIT_C] = ar_c;
      end
      cpurf_pkg::CPURF_FL_LOGIC: begin
        flags_next[cpurf_pkg::BIT_N] = res_sign;
        flags_next[cpurf_pkg::BIT_Z] = res_zero;
        flags_next[cpurf_pkg::BIT_V] = 1'b0;
      end
      cpurf_pkg::CPURF_FL_SHIFT: begin
        flags_next[cpurf_pkg::BIT_N] = res_sign;
        flags_next[cpurf_pkg::BIT_Z] = res_zero;
        flags_next[cpurf_pkg::BIT_V] = 1'b0;
        flags_next[cpurf_pkg::BIT_C] = i_flag_cmd.shift_out;
      end
      cpurf_pkg::CPURF_FL_BITACC: flags_next[cpurf_pkg::BIT_C] = i_flag_cmd.bit_val;
      cpurf_pkg::CPURF_FL_LOAD: flags_next = i_flag_cmd.imm;
      cpurf_pkg::CPURF_FL_AND: flags_next = flags_reg & i_flag_cmd.imm;
      cpurf_pkg::CPURF_FL_OR: flags_next = flags_reg | i_flag_cmd.imm;
      cpurf_pkg::CPURF_FL_XOR: flags_next = flags_reg ^ i_flag_cmd.imm;
      default: flags_next = flags_reg;
    endcase
    // exception entry sets the mask bit over any same-cycle flag instruction; the other bits follow the instruction
    if (i_exc_start) begin
      flags_next[cpurf_pkg::BIT_I] = 1'b1;
    end
  end

  always_comb begin
    ip_next = ip_reg;
    if (i_pc_load) begin
      ip_next = i_pc_data;
    end else if (i_pc_step) begin
      ip_next = (ip_reg & cpurf_pkg::PC_ALIGN_MASK) + 24'h000002;
    end
  end

  // mask flag blocks maskable requests; bit 6 in its mask role blocks those with i_irq_ui_masked
  wire irq_ok = i_irq_req && !flags_reg[cpurf_pkg::BIT_I] &&
                !(i_ui_as_mask && i_irq_ui_masked && flags_reg[cpurf_pkg::BIT_UI]);

  // reset loads only the pointer and mask bit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ip_reg <= i_reset_vector;
      flags_reg[cpurf_pkg::BIT_I] <= 1'b1;
    end else begin
      ip_reg <= ip_next;
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_a_reg <= 32'h00000000;
      rd_b_reg <= 32'h00000000;
      sp_reg <= 32'h00000000;
      fetch_reg <= 24'h000000;
      arith_reg <= 32'h00000000;
      taken_reg <= 1'b0;
      irq_acc_reg <= 1'b0;
      nmi_acc_reg <= 1'b0;
      bus_addr_reg <= 24'h000000;
    end else begin
      rd_a_reg <= view_rd(gen_reg[i_rd_a_idx], i_rd_a_size);
      rd_b_reg <= view_rd(gen_reg[i_rd_b_idx], i_rd_b_size);
      sp_reg <= gen_reg[cpurf_pkg::STACK_IDX];
      fetch_reg <= form_addr(ip_next, i_aspace, 1'b1);
      arith_reg <= ar_res;
      taken_reg <= cond_taken;
      irq_acc_reg <= irq_ok;
      nmi_acc_reg <= i_nmi_req;
      bus_addr_reg <= form_addr(i_eff_addr, i_aspace, i_wide_access);
    end
  end

  assign o_rd_a = rd_a_reg;
  assign o_rd_b = rd_b_reg;
  assign o_stack_ptr = sp_reg;
  assign o_instruction_pointer = ip_reg;
  assign o_fetch_addr = fetch_reg;
  assign o_condition_flags = flags_reg;
  assign o_arith_result = arith_reg;
  assign o_branch_taken = taken_reg;
  assign o_irq_accept = irq_acc_reg;
  assign o_nmi_accept = nmi_acc_reg;
  assign o_bus_addr = bus_addr_reg;
endmodule
`default_nettype wire

// file: testbench/cpurf_top_asserts.sv
// concurrent checks on the ports of the cpu state block
`timescale 1ns/1ps
`default_nettype none
module cpurf_top_asserts (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [23:0] i_reset_vector,
  input wire logic i_sp_wr,
  input wire logic [31:0] i_sp_data,
  input wire logic i_pc_load,
  input wire logic [23:0] i_pc_data,
  input wire logic i_pc_step,
  input wire cpurf_pkg::cpurf_flag_cmd_t i_flag_cmd,
  input wire logic i_exc_start,
  input wire logic i_irq_req,
  input wire logic i_nmi_req,
  input wire cpurf_pkg::cpurf_aspace_t i_aspace,
  input wire logic i_wide_access,
  input wire logic [31:0] o_stack_ptr,
  input wire logic [23:0] o_instruction_pointer,
  input wire logic [23:0] o_fetch_addr,
  input wire logic [7:0] o_condition_flags,
  input wire logic o_irq_accept,
  input wire logic o_nmi_accept,
  input wire logic [23:0] o_bus_addr
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_reset_vector: assert property ($fell(i_sys_rst) |-> o_condition_flags[7]
    && o_instruction_pointer == $past(i_reset_vector)) else $error("reset state wrong");
  a_fetch_even: assert property (!$past(i_sys_rst) && $past(i_aspace) == cpurf_pkg::CPURF_AS_ADVANCED
    |-> o_fetch_addr == (o_instruction_pointer & 24'hFFFFFE)) else $error("fetch address not aligned");
  a_pc_step: assert property (i_pc_step && !i_pc_load |=>
    o_instruction_pointer == ($past(o_instruction_pointer) & 24'hFFFFFE) + 24'h000002) else $error("step wrong");
  a_pc_load: assert property (i_pc_load |=> o_instruction_pointer == $past(i_pc_data))
    else $error("pointer load wrong");
  a_nmi_taken: assert property (i_nmi_req |=> o_nmi_accept) else $error("nmi not accepted");
  a_irq_masked: assert property (i_irq_req && o_condition_flags[7] |=> !o_irq_accept)
    else $error("masked request accepted");
  a_exc_mask: assert property (i_exc_start |=> o_condition_flags[7]) else $error("mask not set");
  a_flag_load: assert property (i_flag_cmd.op == cpurf_pkg::CPURF_FL_LOAD && !i_exc_start |=>
    o_condition_flags == $past(i_flag_cmd.imm)) else $error("flag load wrong");
  a_flags_keep: assert property (i_flag_cmd.op == cpurf_pkg::CPURF_FL_NONE && !i_exc_start |=>
    $stable(o_condition_flags)) else $error("flags changed");
  a_sp_write: assert property (i_sp_wr |-> ##2 o_stack_ptr == $past(i_sp_data, 2))
    else $error("stack pointer wrong");
  a_normal_space: assert property (i_aspace == cpurf_pkg::CPURF_AS_NORMAL |=>
    o_bus_addr[23:16] == 8'h00) else $error("normal address too wide");
  a_mb1_space: assert property (i_aspace == cpurf_pkg::CPURF_AS_MB1 |=>
    o_bus_addr[23:20] == 4'h0) else $error("upper bits kept");
  a_wide_even: assert property (i_wide_access |=> !o_bus_addr[0]) else $error("odd wide address");
endmodule

bind cpurf_top cpurf_top_asserts chk_i (.i_clk, .i_sys_rst, .i_reset_vector, .i_sp_wr, .i_sp_data,
  .i_pc_load, .i_pc_data, .i_pc_step, .i_flag_cmd, .i_exc_start, .i_irq_req, .i_nmi_req, .i_aspace,
  .i_wide_access, .o_stack_ptr, .o_instruction_pointer, .o_fetch_addr, .o_condition_flags,
  .o_irq_accept, .o_nmi_accept, .o_bus_addr);
`default_nettype wire

// file: testbench/cpurf_exec_model.sv
// datapath-side shadow of the general registers as written each cycle
`timescale 1ns/1ps
`default_nettype none
module cpurf_exec_model (
  input wire logic i_clk,
  input wire cpurf_pkg::cpurf_wr_t i_wr,
  input wire logic i_sp_wr,
  input wire logic [31:0] i_sp_data,
  output logic [7:0][31:0] o_regs
);
  function automatic logic [31:0] merge(logic [31:0] r, cpurf_pkg::cpurf_size_t s, logic [31:0] d);
    case (s)
      cpurf_pkg::CPURF_SZ_EXT: return {d[15:0], r[15:0]};
      cpurf_pkg::CPURF_SZ_LOWER: return {r[31:16], d[15:0]};
      cpurf_pkg::CPURF_SZ_HIGH_BYTE: return {r[31:16], d[7:0], r[7:0]};
      cpurf_pkg::CPURF_SZ_LOW_BYTE: return {r[31:8], d[7:0]};
      default: return d;
    endcase
  endfunction

  // unknown until written, like the registers after reset
  always @(posedge i_clk) begin
    if (i_sp_wr) begin
      o_regs[7] <= i_sp_data;
    end
    if (i_wr.en && !(i_sp_wr && i_wr.idx == 3'h7)) begin
      o_regs[i_wr.idx] <= merge(o_regs[i_wr.idx], i_wr.size, i_wr.data);
    end
  end
endmodule
`default_nettype wire

// file: testbench/cpurf_top_tb_top.sv
// self-checking bench for the cpu register and flag state
`timescale 1ns/1ps
`default_nettype none
module cpurf_top_tb_top;
  logic i_clk;
  logic i_sys_rst;
  logic [23:0] i_reset_vector, i_pc_data, i_eff_addr;
  cpurf_pkg::cpurf_wr_t i_wr;
  logic [2:0] i_rd_a_idx, i_rd_b_idx;
  cpurf_pkg::cpurf_size_t i_rd_a_size, i_rd_b_size;
  logic i_sp_wr, i_pc_load, i_pc_step, i_exc_start, i_irq_req;
  logic i_irq_ui_masked, i_ui_as_mask, i_nmi_req, i_wide_access;
  logic [31:0] i_sp_data;
  cpurf_pkg::cpurf_flag_cmd_t i_flag_cmd;
  cpurf_pkg::cpurf_arith_t i_arith;
  cpurf_pkg::cpurf_cond_t i_cond;
  cpurf_pkg::cpurf_aspace_t i_aspace;
  logic [31:0] o_rd_a, o_rd_b, o_stack_ptr, o_arith_result;
  logic [23:0] o_instruction_pointer, o_fetch_addr, o_bus_addr;
  logic [7:0] o_condition_flags;
  logic o_branch_taken, o_irq_accept, o_nmi_accept;
  logic [7:0][31:0] shadow;
  int bad_count = 0;
  int samples_checked = 0;

  cpurf_top dut (.i_clk, .i_sys_rst, .i_reset_vector, .i_wr, .i_rd_a_idx, .i_rd_a_size, .i_rd_b_idx,
    .i_rd_b_size, .i_sp_wr, .i_sp_data, .i_pc_load, .i_pc_data, .i_pc_step, .i_flag_cmd, .i_arith,
    .i_exc_start, .i_irq_req, .i_irq_ui_masked, .i_ui_as_mask, .i_nmi_req, .i_cond, .i_aspace,
    .i_eff_addr, .i_wide_access, .o_rd_a, .o_rd_b, .o_stack_ptr, .o_instruction_pointer,
    .o_fetch_addr, .o_condition_flags, .o_arith_result, .o_branch_taken, .o_irq_accept,
    .o_nmi_accept, .o_bus_addr);
  cpurf_exec_model model (.i_clk, .i_wr, .i_sp_wr, .i_sp_data, .o_regs(shadow));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic tick(int n = 1);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [31:0] view(logic [31:0] r, cpurf_pkg::cpurf_size_t s);
    case (s)
      cpurf_pkg::CPURF_SZ_EXT: return {16'h0000, r[31:16]};
      cpurf_pkg::CPURF_SZ_LOWER: return {16'h0000, r[15:0]};
      cpurf_pkg::CPURF_SZ_HIGH_BYTE: return {24'h000000, r[15:8]};
      cpurf_pkg::CPURF_SZ_LOW_BYTE: return {24'h000000, r[7:0]};
      default: return r;
    endcase
  endfunction

  function automatic int width_of(cpurf_pkg::cpurf_opsz_t s);
    return s == cpurf_pkg::CPURF_OP_BYTE ? 8 : s == cpurf_pkg::CPURF_OP_WORD ? 16 : 32;
  endfunction

  // 33-bit sums: carry or borrow out of the top bit lands in bit w
  function automatic logic [7:0] arith_flags(logic [7:0] f, cpurf_pkg::cpurf_arith_t o, output logic [31:0] res);
    int w, h;
    logic [32:0] r, lo, m, hm, a, b;
    w = width_of(o.opsz);
    h = w - 4;
    m = (33'h1 << w) - 33'h1;
    hm = (33'h1 << h) - 33'h1;
    a = {1'b0, o.a} & m;
    b = {1'b0, o.b} & m;
    r = o.sub ? a - b - 33'(o.cin) : a + b + 33'(o.cin);
    lo = o.sub ? (a & hm) - (b & hm) - 33'(o.cin) : (a & hm) + (b & hm) + 33'(o.cin);
    res = r[31:0] & m[31:0];
    return {f[7:6], lo[h], f[4], r[w-1], res == 32'h0,
      o.sub ? (a[w-1] != b[w-1] && r[w-1] != a[w-1]) : (a[w-1] == b[w-1] && r[w-1] != a[w-1]), r[w]};
  endfunction

  function automatic logic [7:0] op_flags(logic [7:0] f, cpurf_pkg::cpurf_flag_cmd_t c);
    int w;
    logic n, z;
    w = width_of(c.opsz);
    n = c.result[w-1];
    z = 32'(c.result << (32 - w)) == 32'h0;
    case (c.op)
      cpurf_pkg::CPURF_FL_LOGIC: return {f[7:4], n, z, 1'b0, f[0]};
      cpurf_pkg::CPURF_FL_SHIFT: return {f[7:4], n, z, 1'b0, c.shift_out};
      cpurf_pkg::CPURF_FL_BITACC: return {f[7:1], c.bit_val};
      cpurf_pkg::CPURF_FL_LOAD: return c.imm;
      cpurf_pkg::CPURF_FL_AND: return f & c.imm;
      cpurf_pkg::CPURF_FL_OR: return f | c.imm;
      cpurf_pkg::CPURF_FL_XOR: return f ^ c.imm;
      default: return f;
    endcase
  endfunction

  function automatic logic cond_ok(logic [7:0] f, int c);
    logic [15:0] t;
    logic x;
    x = f[3] ^ f[1];
    t = {f[2] | x, !f[2] & !x, x, !x, f[3], !f[3], f[1], !f[1], f[2], !f[2], f[0], !f[0],
      f[0] | f[2], !(f[0] | f[2]), 1'b0, 1'b1};
    return t[c];
  endfunction

  task automatic do_reset;
    i_sys_rst = 1'b1;
    tick(8);
    i_sys_rst = 1'b0;
    tick();
    chk(32'(o_instruction_pointer), 32'(i_reset_vector));
    chk(32'(o_condition_flags[7]), 32'h1);
    $display("test reset done");
  endtask

  task automatic wr(int idx, int sz, logic [31:0] d);
    i_wr.en = 1'b1;
    i_wr.idx = 3'(idx);
    i_wr.size = cpurf_pkg::cpurf_size_t'(sz);
    i_wr.data = d;
    tick();
  endtask

  task automatic set_flags(logic [7:0] v);
    i_flag_cmd.op = cpurf_pkg::CPURF_FL_LOAD;
    i_flag_cmd.imm = v;
    tick();
    i_flag_cmd.op = cpurf_pkg::CPURF_FL_NONE;
  endtask

  task automatic t_regs;
    for (int i = 0; i < 8; i++) wr(i, 0, $urandom);
    for (int k = 0; k < 60; k++) begin
      wr($urandom_range(7), $urandom_range(4), $urandom);
      i_wr.en = 1'b0;
      i_rd_a_idx = 3'($urandom_range(7));
      i_rd_a_size = cpurf_pkg::cpurf_size_t'($urandom_range(4));
      i_rd_b_idx = 3'(k % 8);
      i_rd_b_size = cpurf_pkg::cpurf_size_t'(k % 5);
      tick();
      chk(o_rd_a, view(shadow[i_rd_a_idx], i_rd_a_size));
      chk(o_rd_b, view(shadow[i_rd_b_idx], i_rd_b_size));
    end
    // stack write wins over a datapath write to register 7
    i_sp_wr = 1'b1;
    i_sp_data = $urandom;
    wr(7, 0, ~i_sp_data);
    {i_sp_wr, i_wr.en} = 2'h0;
    tick();
    chk(o_stack_ptr, i_sp_data);
    $display("test registers done");
  endtask

  task automatic t_pc;
    i_pc_load = 1'b1;
    i_pc_step = 1'b1;
    i_pc_data = 24'($urandom) | 24'h000001;
    tick();
    i_pc_load = 1'b0;
    chk(32'(o_instruction_pointer), 32'(i_pc_data));
    tick();
    i_pc_step = 1'b0;
    chk(32'(o_instruction_pointer), 32'((i_pc_data & 24'hFFFFFE) + 24'h000002));
    chk(32'(o_fetch_addr), 32'((i_pc_data & 24'hFFFFFE) + 24'h000002));
    $display("test pointer done");
  endtask

  task automatic t_flags;
    logic [7:0] f;
    logic [31:0] res;
    cpurf_pkg::cpurf_arith_t a;
    set_flags(8'h50);
    chk(32'(o_condition_flags), 32'h50);
    tick();
    for (int k = 0; k < 45; k++) begin
      f = o_condition_flags;
      a.opsz = cpurf_pkg::cpurf_opsz_t'(k % 3);
      a.sub = k < 3 ? 1'b0 : 1'($urandom);
      a.a = k == 0 ? 32'hF : k == 1 ? 32'hFFF : k == 2 ? 32'hFFFFFFF : $urandom;
      a.b = k < 3 ? 32'h1 : k % 7 == 0 ? a.a : $urandom;
      a.cin = k < 3 ? 1'b0 : 1'($urandom);
      i_arith = a;
      i_flag_cmd.op = cpurf_pkg::CPURF_FL_ARITH;
      i_flag_cmd.opsz = a.opsz;
      tick();
      chk(32'(o_condition_flags), 32'(arith_flags(f, a, res)));
      chk(o_arith_result & (32'hFFFFFFFF >> (32 - width_of(a.opsz))), res);
    end
    for (int k = 0; k < 32; k++) begin
      f = o_condition_flags;
      i_flag_cmd.op = cpurf_pkg::cpurf_flop_t'(k % 8 == 0 ? 0 : 1 + k % 8);
      i_flag_cmd.opsz = cpurf_pkg::cpurf_opsz_t'($urandom_range(2));
      i_flag_cmd.result = k % 3 == 0 ? 32'h0 : $urandom;
      i_flag_cmd.shift_out = 1'($urandom);
      i_flag_cmd.bit_val = 1'($urandom);
      i_flag_cmd.imm = 8'($urandom);
      tick();
      chk(32'(o_condition_flags), 32'(op_flags(f, i_flag_cmd)));
    end
    $display("test flags done");
  endtask

  task automatic t_cond;
    for (int c = 0; c < 32; c++) begin
      i_cond = cpurf_pkg::cpurf_cond_t'(c % 16);
      set_flags(8'($urandom));
      tick();
      chk(32'(o_branch_taken), 32'(cond_ok(i_flag_cmd.imm, c % 16)));
    end
    $display("test branch done");
  endtask

  task automatic t_irq;
    for (int k = 0; k < 16; k++) begin
      set_flags({k[0], k[1], 6'h00});
      i_ui_as_mask = k[2];
      i_irq_ui_masked = k[3];
      i_irq_req = 1'b1;
      i_nmi_req = 1'b1;
      tick();
      chk(32'(o_irq_accept), 32'(!k[0] && !(k[1] && k[2] && k[3])));
      chk(32'(o_nmi_accept), 32'h1);
    end
    set_flags(8'h00);
    i_irq_req = 1'b0;
    i_nmi_req = 1'b0;
    i_exc_start = 1'b1;
    tick();
    i_exc_start = 1'b0;
    chk(32'({o_condition_flags[7], o_nmi_accept}), 32'h2);
    $display("test interrupts done");
  endtask

  task automatic t_addr;
    for (int k = 0; k < 30; k++) begin
      i_aspace = cpurf_pkg::cpurf_aspace_t'(k % 3);
      i_wide_access = k % 4 < 2;
      i_eff_addr = 24'($urandom);
      tick();
      chk(32'(o_bus_addr), 32'(i_eff_addr & (k % 3 == 0 ? 24'h00FFFF : k % 3 == 1 ? 24'h0FFFFF :
        24'hFFFFFF) & {23'h7FFFFF, !i_wide_access}));
    end
    i_aspace = cpurf_pkg::CPURF_AS_ADVANCED;
    $display("test address done");
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_wr = '0;
    {i_rd_a_idx, i_rd_b_idx} = 6'h00;
    i_rd_a_size = cpurf_pkg::CPURF_SZ_LONG;
    i_rd_b_size = cpurf_pkg::CPURF_SZ_LONG;
    {i_sp_wr, i_pc_load, i_pc_step, i_exc_start, i_irq_req} = 5'h00;
    {i_irq_ui_masked, i_ui_as_mask, i_nmi_req, i_wide_access} = 4'h0;
    {i_sp_data, i_pc_data, i_eff_addr} = 80'h0;
    i_flag_cmd = '0;
    i_arith = '0;
    i_cond = cpurf_pkg::CPURF_CC_T;
    i_aspace = cpurf_pkg::CPURF_AS_ADVANCED;
    void'($urandom(32'h4615));
    i_reset_vector = 24'($urandom);
    do_reset;
    t_regs;
    t_pc;
    t_flags;
    t_cond;
    t_irq;
    t_addr;
    i_reset_vector = 24'($urandom);
    do_reset;
    close_out;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
